/* File: common/htc_consts.vh */
`ifndef HTC_CONSTS_VH
`define HTC_CONSTS_VH

// ==========================================================
// Register byte offsets
`define HTC_CTRL_OFF     8'h00
`define HTC_TOP_OFF      8'h04
`define HTC_CMP_OFF      8'h08
`define HTC_CNT_OFF      8'h0c
`define HTC_CAP_OFF      8'h10
`define HTC_STAT_OFF     8'h14
`define HTC_MASK_OFF     8'h18

// ==========================================================
// Control fields
`define HTC_CTRL_EN      0
`define HTC_CTRL_MODE_LO 1
`define HTC_CTRL_MODE_HI 2
`define HTC_CTRL_SRC     3
`define HTC_CTRL_PRE_LO  4
`define HTC_CTRL_PRE_HI  6
`define HTC_CTRL_CAPEN   7
`define HTC_CTRL_BUS     8
`define HTC_CTRL_INV     9
`define HTC_CTRL_RSTEN   10
`define HTC_CTRL_WAKEEN  11
`define HTC_CTRL_W       12

// ==========================================================
// Modes
`define HTC_MODE_WDT     2'h0
`define HTC_MODE_CTC     2'h1
`define HTC_MODE_FAST    2'h2
`define HTC_MODE_PFC     2'h3

// ==========================================================
// Status bits
`define HTC_ST_OVF       0
`define HTC_ST_CMP       1
`define HTC_ST_CAP       2

// ==========================================================
// Preloaded (stand-alone) reset values
`define HTC_CTRL_RST     12'h401
`define HTC_TOP_RST      16'hffff
`define HTC_CMP_RST      16'h8000
`define HTC_MASK_RST     3'h0

`endif

/* File: core/htc_prescaler.v */
`timescale 1ns/10ps
module htc_prescaler (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       clear,
    input  wire       srcTick,
    input  wire [2:0] sel,
    output reg        tick
);
    reg  [9:0] divCnt;
    reg  [9:0] divLast;

    // ==========================================================
    // Divide ratio 1, 2, 8, 32, 64, 128, 256, 1024
    always @* begin
        case (sel)
            3'h0:    divLast = 10'h000;
            3'h1:    divLast = 10'h001;
            3'h2:    divLast = 10'h007;
            3'h3:    divLast = 10'h01f;
            3'h4:    divLast = 10'h03f;
            3'h5:    divLast = 10'h07f;
            3'h6:    divLast = 10'h0ff;
            default: divLast = 10'h3ff;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= 10'h000;
            tick   <= 1'b0;
        end else if (clear) begin
            divCnt <= 10'h000;
            tick   <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (srcTick) begin
                if (divCnt >= divLast) begin
                    divCnt <= 10'h000;
                    tick   <= 1'b1;
                end else begin
                    divCnt <= divCnt + 10'h001;
                end
            end
        end
    end
endmodule // htc_prescaler

/* File: core/htc_timer.v */
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "htc_consts.vh"
module htc_timer (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        timer_clock_in,
    input  wire        timer_reset_n,
    input  wire        capture_trigger_in,
    output reg         timer_irq_out,
    output reg         wake_irq_out,
    output reg         waveform_out
);
    // ==========================================================
    // Pin synchronisers: bit0 clock, bit1 reset, bit2 capture
    reg  [2:0]  pinS1;
    reg  [2:0]  pinS2;
    reg  [2:0]  pinS3;
    reg  [2:0]  pinF;
    reg  [2:0]  pinFPrev;
    wire [2:0]  pinAgree;

    assign pinAgree = ~(pinS2 ^ pinS3);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    pinS1[gi]    <= (gi == 1);
                    pinS2[gi]    <= (gi == 1);
                    pinS3[gi]    <= (gi == 1);
                    pinF[gi]     <= (gi == 1);
                    pinFPrev[gi] <= (gi == 1);
                end else begin
                    pinS1[gi] <= (gi == 0) ? timer_clock_in :
                                 (gi == 1) ? timer_reset_n :
                                 capture_trigger_in;
                    pinS2[gi] <= pinS1[gi];
                    pinS3[gi] <= pinS2[gi];
                    if (pinAgree[gi]) begin
                        pinF[gi] <= pinS3[gi];
                    end
                    pinFPrev[gi] <= pinF[gi];
                end
            end
        end
    endgenerate

    wire extClkRise = pinF[0] & ~pinFPrev[0];
    wire capRise    = pinF[2] & ~pinFPrev[2];

    // ==========================================================
    // Registers
    reg  [11:0] ctrl;
    reg  [15:0] topReg;
    reg  [15:0] cmpReg;
    reg  [15:0] topAct;
    reg  [15:0] cmpAct;
    reg  [15:0] count_value;
    reg  [15:0] capture_value_reg;
    reg  [2:0]  status;
    reg  [2:0]  mask;
    reg         countUp;

    wire [1:0] mode    = ctrl[`HTC_CTRL_MODE_HI:`HTC_CTRL_MODE_LO];
    wire       enable  = ctrl[`HTC_CTRL_EN];
    wire       busMode = ctrl[`HTC_CTRL_BUS];
    wire       isPwm   = mode[1];
    // Reset pin enable is read-only one; the pin cannot be disabled
    wire       reset_pin_enable = 1'b1;
    wire       timerRst = reset_pin_enable & ~pinF[1];

    // ==========================================================
    // Bus decode
    wire busAcc  = psel & penable & ~pready;
    wire busWr   = busAcc & pwrite;
    wire mapped  = (paddr == `HTC_CTRL_OFF) | (paddr == `HTC_TOP_OFF) |
                   (paddr == `HTC_CMP_OFF)  | (paddr == `HTC_CNT_OFF) |
                   (paddr == `HTC_CAP_OFF)  | (paddr == `HTC_STAT_OFF) |
                   (paddr == `HTC_MASK_OFF);
    wire wrCtrl  = busWr & (paddr == `HTC_CTRL_OFF);
    wire wrTop   = busWr & (paddr == `HTC_TOP_OFF);
    wire wrCmp   = busWr & (paddr == `HTC_CMP_OFF);
    wire wrCnt   = busWr & (paddr == `HTC_CNT_OFF);
    wire wrStat  = busWr & (paddr == `HTC_STAT_OFF);
    wire wrMask  = busWr & (paddr == `HTC_MASK_OFF);

    // ==========================================================
    // Clock source and prescaler
    wire srcTick = ctrl[`HTC_CTRL_SRC] ? extClkRise : 1'b1;
    wire tick;

    htc_prescaler uPre (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clear   (timerRst | ~enable),
        .srcTick (srcTick),
        .sel     (ctrl[`HTC_CTRL_PRE_HI:`HTC_CTRL_PRE_LO]),
        .tick    (tick)
    );

    wire step = tick & enable & ~timerRst;

    // ==========================================================
    // Counter next state
    reg  [15:0] next_count;
    reg         next_up;
    reg         wrapEvt;
    reg         loadBuf;
    reg  [15:0] limit;

    always @* begin
        next_count = count_value;
        next_up    = countUp;
        wrapEvt    = 1'b0;
        loadBuf    = ~isPwm;
        limit      = (mode == `HTC_MODE_CTC) ? cmpAct : topAct;
        if (step) begin
            if (mode != `HTC_MODE_PFC) begin
                if (count_value >= limit) begin
                    next_count = 16'h0000;
                    next_up    = 1'b1;
                    wrapEvt    = 1'b1;
                    loadBuf    = 1'b1;
                end else begin
                    next_count = count_value + 16'h0001;
                end
            end else if (countUp) begin
                if (count_value >= topAct) begin
                    next_up    = 1'b0;
                    next_count = (topAct == 16'h0000) ? 16'h0000 :
                                 count_value - 16'h0001;
                end else begin
                    next_count = count_value + 16'h0001;
                end
            end else begin
                if (count_value == 16'h0000) begin
                    next_up    = 1'b1;
                    next_count = (topAct == 16'h0000) ? 16'h0000 :
                                 16'h0001;
                    wrapEvt    = 1'b1;
                    loadBuf    = 1'b1;
                end else begin
                    next_count = count_value - 16'h0001;
                end
            end
        end
    end

    wire cmpEvt = step & (count_value == cmpAct);
    wire capEvt = capRise & ctrl[`HTC_CTRL_CAPEN] & busMode & ~isPwm;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= 16'h0000;
            countUp     <= 1'b1;
            topAct      <= `HTC_TOP_RST;
            cmpAct      <= `HTC_CMP_RST;
        end else if (timerRst) begin
            count_value <= 16'h0000;
            countUp     <= 1'b1;
            topAct      <= topReg;
            cmpAct      <= cmpReg;
        end else begin
            if (wrCnt) begin
                count_value <= pwdata[15:0];
            end else begin
                count_value <= next_count;
            end
            countUp <= next_up;
            // PWM limits only change at a period boundary
            if (loadBuf) begin
                topAct <= topReg;
                cmpAct <= cmpReg;
            end
        end
    end

    // ==========================================================
    // Capture
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            capture_value_reg <= 16'h0000;
        end else if (capEvt) begin
            capture_value_reg <= count_value;
        end
    end

    // ==========================================================
    // Waveform
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waveform_out <= 1'b0;
        end else if (!enable) begin
            waveform_out <= ctrl[`HTC_CTRL_INV];
        end else if (isPwm) begin
            // From the flopped count so no combinational glitch
            waveform_out <= (count_value < cmpAct) ^
                            ctrl[`HTC_CTRL_INV];
        end else if ((mode == `HTC_MODE_CTC) ? cmpEvt : wrapEvt) begin
            waveform_out <= ~waveform_out;
        end
    end

    // ==========================================================
    // Control registers, stand-alone values are the reset values
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl   <= `HTC_CTRL_RST;
            topReg <= `HTC_TOP_RST;
            cmpReg <= `HTC_CMP_RST;
            mask   <= `HTC_MASK_RST;
        end else begin
            if (wrCtrl) begin
                ctrl <= pwdata[`HTC_CTRL_W-1:0] |
                        (12'h001 << `HTC_CTRL_RSTEN);
            end
            if (wrTop) begin
                topReg <= pwdata[15:0];
            end
            if (wrCmp) begin
                cmpReg <= pwdata[15:0];
            end
            if (wrMask) begin
                mask <= pwdata[2:0];
            end
        end
    end

    // ==========================================================
    // Status, set wins over write-one-to-clear
    wire [2:0] evt = {capEvt, cmpEvt, wrapEvt};
    wire [2:0] clr = wrStat ? pwdata[2:0] : 3'h0;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 3'h0;
        end else begin
            status <= (status & ~clr) | evt;
        end
    end

    // ==========================================================
    // Interrupt outputs
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_out <= 1'b0;
            wake_irq_out  <= 1'b0;
        end else begin
            if (busMode) begin
                timer_irq_out <= |(status & mask);
            end else begin
                timer_irq_out <= status[`HTC_ST_OVF];
            end
            wake_irq_out <= ctrl[`HTC_CTRL_WAKEEN] &
                            (|(status & mask));
        end
    end

    // ==========================================================
    // Bus slave: one wait cycle, then a single-cycle ready
    reg [31:0] rdMux;

    always @* begin
        case (paddr)
            `HTC_CTRL_OFF: rdMux = {20'h00000, ctrl};
            `HTC_TOP_OFF:  rdMux = {16'h0000, topReg};
            `HTC_CMP_OFF:  rdMux = {16'h0000, cmpReg};
            `HTC_CNT_OFF:  rdMux = {16'h0000, count_value};
            `HTC_CAP_OFF:  rdMux = {16'h0000, capture_value_reg};
            `HTC_STAT_OFF: rdMux = {29'h0, status};
            `HTC_MASK_OFF: rdMux = {29'h0, mask};
            default:       rdMux = 32'h00000000;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= busAcc;
            pslverr <= busAcc & ~mapped;
            if (busAcc & ~pwrite) begin
                prdata <= rdMux;
            end
        end
    end
endmodule // htc_timer

/* File: bench/htc_timer_monitor.sv */
`timescale 1ns/10ps
`include "htc_consts.vh"
module htc_timer_monitor (
    input wire        mclk,
    input wire        rst_n,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        timer_clock_in,
    input wire        timer_reset_n,
    input wire        capture_trigger_in,
    input wire        timer_irq_out,
    input wire        wake_irq_out,
    input wire        waveform_out
);
    // ==============================
    // Bus and interrupt checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire accWait = psel && penable && !pready;
    wire rdDone  = pready && !pwrite;
    a_ready_one_wait: assert property (accWait |=> pready)
        else $error("ready missing after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (accWait && paddr > `HTC_MASK_OFF
        |=> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (accWait && paddr <= `HTC_MASK_OFF
        && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_unmapped_zero: assert property (rdDone && pslverr
        |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rsten_held: assert property (rdDone && paddr == `HTC_CTRL_OFF
        |-> prdata[10] && prdata[31:12] == 20'h0)
        else $error("reset pin enable not held");
    a_count_width: assert property (rdDone && paddr == `HTC_CNT_OFF
        |-> prdata[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    a_irq_fall_write: assert property ($fell(timer_irq_out)
        |-> $past(pready && pwrite))
        else $error("interrupt fell without a write");
    cover property (pready && pslverr);
    cover property ($rose(timer_irq_out));
    cover property ($rose(wake_irq_out));
endmodule // htc_timer_monitor

bind htc_timer htc_timer_monitor i_mon (
    .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_clock_in(timer_clock_in), .timer_reset_n(timer_reset_n),
    .capture_trigger_in(capture_trigger_in),
    .timer_irq_out(timer_irq_out), .wake_irq_out(wake_irq_out),
    .waveform_out(waveform_out)
);

/* File: bench/htc_apb_host.sv */
`timescale 1ns/10ps
module htc_apb_host (
    input  wire        mclk,
    output reg  [7:0]  paddr,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    reg [31:0] rdat;
    reg        rerr;
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    // ==============================
    // One transfer, held until ready is sampled
    task xfer(input [7:0] a, input w, input [31:0] d);
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait for ready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not look valid
        pwdata <= ~d;
    endtask
endmodule // htc_apb_host

/* File: bench/htc_timer_tb.sv */
`timescale 1ns/10ps
`include "htc_consts.vh"
`define CHK(nm, e, a) begin \
    checksDone++; \
    if ((a) !== (e)) begin \
        errTotal++; \
        $display("wrong value %s exp %0h got %0h", nm, e, a); \
    end \
end
module htc_timer_tb;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         timerResetN = 1'b1;
    reg         trig = 1'b0;
    reg  [1:0]  pinDiv = 2'h0;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata;
    wire        psel, penable, pwrite, pready, pslverr, irq, wake, wave;
    int         errTotal = 0;
    int         checksDone = 0;
    int         rises;
    reg         prev;
    reg  [11:0] modeCtrl [0:6] = '{12'h101, 12'h103, 12'h105, 12'h107,
                                   12'h10b, 12'h113, 12'h123};
    int         modeRise [0:6] = '{30, 60, 60, 40, 15, 30, 8};

    initial forever #5 mclk = ~mclk;
    // Pin source ticks once every four cycles
    always @(posedge mclk) pinDiv <= pinDiv + 2'h1;

    htc_apb_host i_host (.mclk(mclk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    htc_timer i_dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_clock_in(pinDiv[1]), .timer_reset_n(timerResetN),
        .capture_trigger_in(trig), .timer_irq_out(irq),
        .wake_irq_out(wake), .waveform_out(wave));

    // ==============================
    // Access and closing tasks
    task stopTest;
        $display("checks %0d errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        i_host.xfer(a, 1'b1, d);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        i_host.xfer(a, 1'b0, 32'h0);
        `CHK($sformatf("reg %0h", a), e, i_host.rdat)
    endtask
    // Rising edges counted, so output polarity does not matter
    task runMode(input [11:0] c, input int ex);
        wr(`HTC_CTRL_OFF, {20'h0, c});
        wr(`HTC_CNT_OFF, 32'h0);
        repeat (20) @(negedge mclk);
        rises = 0;
        prev = wave;
        repeat (240) begin
            @(negedge mclk);
            if (wave && !prev) rises++;
            prev = wave;
        end
        `CHK("rises", 1'b1, (rises >= ex - 1 && rises <= ex + 1))
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        stopTest;
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`HTC_CTRL_OFF, 32'h401);
        rd(`HTC_TOP_OFF, 32'hffff);
        rd(`HTC_CMP_OFF, 32'h8000);
        rd(`HTC_MASK_OFF, 32'h0);
        rd(`HTC_STAT_OFF, 32'h0);
        rd(8'h1c, 32'h0);
        `CHK("slave error", 1'b1, i_host.rerr)
        wr(`HTC_CAP_OFF, 32'h1234);
        rd(`HTC_CAP_OFF, 32'h0);
        wr(`HTC_TOP_OFF, 32'hffff0003);
        rd(`HTC_TOP_OFF, 32'h3);
        wr(`HTC_CMP_OFF, 32'h1);
        for (int i = 0; i < 7; i++) begin
            runMode(modeCtrl[i], modeRise[i]);
        end
        // ==============================
        // Interrupt raise, mask and clear
        wr(`HTC_CTRL_OFF, 32'h100);
        wr(`HTC_STAT_OFF, 32'h7);
        wr(`HTC_MASK_OFF, 32'h1);
        rd(`HTC_STAT_OFF, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(`HTC_CTRL_OFF, 32'h901);
        repeat (10) @(negedge mclk);
        wr(`HTC_CTRL_OFF, 32'h900);
        repeat (3) @(negedge mclk);
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        rd(`HTC_STAT_OFF, 32'h3);
        wr(`HTC_MASK_OFF, 32'h0);
        repeat (3) @(negedge mclk);
        `CHK("irq", 1'b0, irq)
        `CHK("wake", 1'b0, wake)
        wr(`HTC_STAT_OFF, 32'h1);
        rd(`HTC_STAT_OFF, 32'h2);
        wr(`HTC_STAT_OFF, 32'h7);
        wr(`HTC_CTRL_OFF, 32'h001);
        repeat (20) @(negedge mclk);
        `CHK("irq", 1'b1, irq)
        @(posedge mclk);
        timerResetN <= 1'b0;
        repeat (10) @(negedge mclk);
        rd(`HTC_CNT_OFF, 32'h0);
        rd(`HTC_TOP_OFF, 32'h3);
        timerResetN <= 1'b1;
        // ==============================
        // Capture time stamp
        wr(`HTC_CTRL_OFF, 32'h180);
        wr(`HTC_TOP_OFF, 32'hffff);
        wr(`HTC_STAT_OFF, 32'h7);
        wr(`HTC_CNT_OFF, 32'h0);
        wr(`HTC_CTRL_OFF, 32'h181);
        repeat (50) @(posedge mclk);
        trig <= 1'b1;
        repeat (5) @(posedge mclk);
        trig <= 1'b0;
        wr(`HTC_CTRL_OFF, 32'h180);
        i_host.xfer(`HTC_CAP_OFF, 1'b0, 32'h0);
        `CHK("cap", 1'b1, (i_host.rdat >= 48 && i_host.rdat <= 62))
        rd(`HTC_STAT_OFF, 32'h6);
        // ==============================
        // Idle level follows the invert bit
        wr(`HTC_CTRL_OFF, 32'h200);
        repeat (2) @(negedge mclk);
        `CHK("wave", 1'b1, wave)
        stopTest;
    end
endmodule // htc_timer_tb
